/* File: common/wd_pkg.sv */
// constants and types shared by the windowed watchdog design
// assumes one system clock; watchdog source clocks arrive as one-cycle enable pulses
// Summary of operation
// - chip reset request, or interrupt in interrupt mode, when the counter runs out before software reloads it
// - in windowed operation a feed is taken only inside the programmed window
// - optional warning interrupt at a programmable count before the time-out
// - enable is set by software and cleared only by reset or watchdog event
// - wrong feed sequence while enabled raises chip reset, or interrupt when interrupt mode chosen
// - a flag records that the watchdog caused a reset
// - 24-bit timer behind a divide-by-four prescaler, period 256 to 2^24 counts
// - counting clock normally comes from the dedicated watchdog oscillator
// - internal RC oscillator selectable as alternative counting clock
package wd_pkg;
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] cnt_t;
  localparam int PRESCALE = 4;
  localparam cnt_t TC_MIN = 24'h0000FF;
  localparam cnt_t TC_RST = 24'hFFFFFF;
  localparam cnt_t WIN_OFF = 24'hFFFFFF;
  localparam cnt_t CNT_RST = 24'hFFFFFF;
  // feed key values are arbitrary
  localparam logic [7:0] FEED_KEY1 = 8'h5A;
  localparam logic [7:0] FEED_KEY2 = 8'hC3;
  localparam logic SRC_WATCHDOG_OSC = 1'b0;
  localparam logic SRC_RC_OSC = 1'b1;
  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_KEYED = 2'b10
  } feed_state_e;
endpackage : wd_pkg

/* File: verilog/count_tick_sel.sv */
// counting-clock source select and fixed prescaler for the watchdog
// assumes source ticks are one-cycle pulses synchronous to clk
`timescale 1ns/1ps
module count_tick_sel #(
  parameter int DIV = wd_pkg::PRESCALE
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic src_sel, // 0 watchdog oscillator, 1 internal rc oscillator
  input wire logic osc_tick, // watchdog oscillator tick
  input wire logic rc_tick, // internal rc oscillator tick
  input wire logic run, // counting enabled
  output logic tick // one pulse per DIV source ticks
);
  import wd_pkg::*;
  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);
  logic [PW-1:0] pre_r, pre_nxt;
  logic tick_nxt, src_tick;

  always_comb begin
    src_tick = (src_sel == SRC_RC_OSC) ? rc_tick : osc_tick;
    pre_nxt = pre_r;
    tick_nxt = 1'b0;
    if (!run) begin
      pre_nxt = '0;
    end else if (src_tick) begin
      if (pre_r == PRE_LAST) begin
        pre_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        pre_nxt = pre_r + PW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
      tick <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tick <= tick_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  src_tick_a: assert property (tick |-> $past(run && src_tick))
    else $error("tick without selected source tick");
  prescale_gap_a: assert property (tick |=> !tick)
    else $error("prescaler ticks back to back");
  src_rc_c: cover property (run && src_sel == SRC_RC_OSC && tick);
endmodule : count_tick_sel

/* File: verilog/windowed_watchdog.sv */
// windowed watchdog: 24-bit down counter, feed sequencer, window and warning logic
// assumes control bits are plain synchronous inputs and FEED_WR is a one-cycle strobe
`timescale 1ns/1ps
module windowed_watchdog #(
  parameter int DIV = wd_pkg::PRESCALE
) (
  input wire logic CLK_SYS, // 40 MHz system clock
  input wire logic RST, // async reset, high
  input wire logic ENABLE_SET, // pulse: software enables watchdog
  input wire logic RESET_MODE, // 1 reset on event, 0 interrupt
  input wire logic SRC_SEL, // counting clock source
  input wire logic OSC_TICK, // watchdog oscillator tick
  input wire logic RC_TICK, // internal rc oscillator tick
  input wire wd_pkg::cnt_t TC_VAL, // time-out reload value
  input wire wd_pkg::cnt_t WINDOW_VAL, // feed allowed at or below this count
  input wire logic WARN_EN, // warning interrupt enable
  input wire wd_pkg::cnt_t WARN_VAL, // warning count
  input wire logic FEED_WR, // feed write strobe
  input wire logic [7:0] FEED_DATA, // feed write data
  input wire logic INT_CLR, // clear event interrupt flag
  input wire logic WARN_CLR, // clear warning flag
  input wire logic FLAG_CLR, // clear watchdog reset flag
  output logic ENABLED, // watchdog running
  output wd_pkg::cnt_t COUNT, // current count
  output logic CHIP_RESET_REQ, // one-cycle chip reset request
  output logic RESET_FLAG, // watchdog caused a reset
  output logic WDOG_INT, // event interrupt, sticky
  output logic WARN_INT // warning interrupt, sticky
);
  import wd_pkg::*;

  feed_state_e feed_r, feed_nxt;
  logic en_nxt, crst_nxt, rflag_nxt, int_nxt, warn_nxt;
  cnt_t cnt_nxt, tc_eff;
  logic tick, key_ok, key_bad, seq_done, in_window, good_feed, bad_feed;
  logic timeout, warn_hit, event_hit;

  // prescaler restarts whenever the watchdog is off
  count_tick_sel #(.DIV(DIV)) u_tick (
    .clk(CLK_SYS),
    .rst(RST),
    .src_sel(SRC_SEL),
    .osc_tick(OSC_TICK),
    .rc_tick(RC_TICK),
    .run(ENABLED),
    .tick(tick)
  );

  // feed sequencer
  always_comb begin
    feed_nxt = feed_r;
    key_ok = 1'b0;
    key_bad = 1'b0;
    seq_done = 1'b0;
    if (FEED_WR) begin
      case (feed_r)
        FEED_IDLE: begin
          if (FEED_DATA == FEED_KEY1) begin
            feed_nxt = FEED_KEYED;
          end else begin
            key_bad = 1'b1;
          end
        end
        FEED_KEYED: begin
          feed_nxt = FEED_IDLE;
          seq_done = 1'b1;
          key_ok = (FEED_DATA == FEED_KEY2);
          key_bad = (FEED_DATA != FEED_KEY2);
        end
        default: begin
          feed_nxt = FEED_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    // short reload values would push the period below its floor
    tc_eff = (TC_VAL < TC_MIN) ? TC_MIN : TC_VAL;
    in_window = (COUNT <= WINDOW_VAL);
    good_feed = seq_done && key_ok && in_window;
    // disabled block still reloads on a good feed but ignores a bad one
    bad_feed = ENABLED && (key_bad || (seq_done && key_ok && !in_window));
    timeout = ENABLED && tick && (COUNT == '0);
    warn_hit = ENABLED && tick && WARN_EN && (COUNT == WARN_VAL);
    event_hit = timeout || bad_feed;
  end

  // counter, enable and flags
  always_comb begin
    en_nxt = ENABLED;
    cnt_nxt = COUNT;
    crst_nxt = 1'b0;
    rflag_nxt = RESET_FLAG && !FLAG_CLR;
    int_nxt = WDOG_INT && !INT_CLR;
    warn_nxt = (WARN_INT && !WARN_CLR) || warn_hit;
    // event outranks enable, feed and tick landing in the same cycle
    if (event_hit) begin
      en_nxt = 1'b0;
      cnt_nxt = tc_eff;
      if (RESET_MODE) begin
        crst_nxt = 1'b1;
        rflag_nxt = 1'b1;
      end else begin
        int_nxt = 1'b1;
      end
    end else begin
      if (ENABLE_SET && !ENABLED) begin
        en_nxt = 1'b1;
        cnt_nxt = tc_eff;
      end else if (good_feed) begin
        cnt_nxt = tc_eff;
      end else if (ENABLED && tick) begin
        cnt_nxt = COUNT - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      feed_r <= FEED_IDLE;
      ENABLED <= 1'b0;
      COUNT <= CNT_RST;
      CHIP_RESET_REQ <= 1'b0;
      RESET_FLAG <= 1'b0;
      WDOG_INT <= 1'b0;
      WARN_INT <= 1'b0;
    end else begin
      feed_r <= feed_nxt;
      ENABLED <= en_nxt;
      COUNT <= cnt_nxt;
      CHIP_RESET_REQ <= crst_nxt;
      RESET_FLAG <= rflag_nxt;
      WDOG_INT <= int_nxt;
      WARN_INT <= warn_nxt;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // feed and mode
  feed_reload_a: assert property (!event_hit && good_feed && ENABLED |=> COUNT == $past(tc_eff))
    else $error("feed did not reload counter");
  feed_keeps_mode_a: assert property (!event_hit && good_feed && ENABLED |=> ENABLED)
    else $error("feed changed enable");
  enable_sticky_a: assert property (ENABLED && !timeout && !bad_feed |=> ENABLED)
    else $error("enable cleared without event");
  timeout_reset_a: assert property (timeout && RESET_MODE |=> CHIP_RESET_REQ && RESET_FLAG && !ENABLED)
    else $error("time-out gave no chip reset");
  window_refuse_a: assert property (ENABLED && seq_done && key_ok && COUNT > WINDOW_VAL && !RESET_MODE
    |=> WDOG_INT && !ENABLED)
    else $error("early feed not refused");
  warn_set_a: assert property (ENABLED && tick && WARN_EN && COUNT == WARN_VAL |=> WARN_INT)
    else $error("warning not raised");
  bad_key_a: assert property (ENABLED && FEED_WR && feed_r == FEED_IDLE && FEED_DATA != FEED_KEY1
    |=> (CHIP_RESET_REQ || WDOG_INT) && !ENABLED)
    else $error("bad feed key not punished");
  reset_flag_a: assert property (RESET_FLAG && !FLAG_CLR |=> RESET_FLAG)
    else $error("reset flag lost");
  count_hold_a: assert property (ENABLED && !tick && !event_hit && !good_feed |=> $stable(COUNT))
    else $error("count moved without tick");
  req_pulse_a: assert property (CHIP_RESET_REQ |=> !CHIP_RESET_REQ)
    else $error("reset request longer than one cycle");
  key1_arm_a: assert property (FEED_WR && feed_r == FEED_IDLE && FEED_DATA == FEED_KEY1
    |=> feed_r == FEED_KEYED)
    else $error("first feed key not taken");
  second_key_a: assert property (ENABLED && !WDOG_INT && !RESET_MODE && FEED_WR
    && feed_r == FEED_KEYED && FEED_DATA != FEED_KEY2 |=> WDOG_INT && !ENABLED)
    else $error("bad second feed key not punished");
  window_accept_a: assert property (ENABLED && !timeout && seq_done && key_ok
    && COUNT <= WINDOW_VAL |=> ENABLED && !CHIP_RESET_REQ && COUNT == $past(tc_eff))
    else $error("feed inside window refused");

  // enable, disable and counting
  enable_load_a: assert property (ENABLE_SET && !ENABLED
    |=> ENABLED && COUNT == $past(tc_eff))
    else $error("enable did not load counter");
  off_hold_a: assert property (!ENABLED && !ENABLE_SET && !good_feed
    |=> $stable(COUNT) && !ENABLED)
    else $error("disabled counter moved");
  event_off_a: assert property (event_hit
    |=> !ENABLED && COUNT == $past(tc_eff))
    else $error("event left watchdog running");
  tick_step_a: assert property (ENABLED && tick && !event_hit && !good_feed
    |=> COUNT == $past(COUNT) - CNT_W'(1))
    else $error("tick did not count down");

  // event outcome
  req_cause_a: assert property (CHIP_RESET_REQ
    |-> $past(event_hit && RESET_MODE))
    else $error("reset request without event");
  idle_no_req_a: assert property (!ENABLED
    |=> !CHIP_RESET_REQ)
    else $error("reset request while disabled");
  reset_cause_a: assert property (event_hit && RESET_MODE
    |=> RESET_FLAG && CHIP_RESET_REQ)
    else $error("reset event not flagged");
  int_mode_a: assert property (event_hit && !RESET_MODE
    |=> WDOG_INT && !CHIP_RESET_REQ)
    else $error("interrupt mode event wrong");

  // flags
  flag_clear_a: assert property (FLAG_CLR && !(event_hit && RESET_MODE)
    |=> !RESET_FLAG)
    else $error("reset flag not cleared");
  int_clear_a: assert property (INT_CLR && !(event_hit && !RESET_MODE)
    |=> !WDOG_INT)
    else $error("event interrupt not cleared");
  int_hold_a: assert property (WDOG_INT && !INT_CLR
    |=> WDOG_INT)
    else $error("event interrupt lost");
  warn_hold_a: assert property (WARN_INT && !WARN_CLR
    |=> WARN_INT)
    else $error("warning lost");
  warn_quiet_a: assert property (!WARN_EN && !WARN_INT
    |=> !WARN_INT)
    else $error("warning while disabled");
  warn_cause_a: assert property ($rose(WARN_INT)
    |-> $past(warn_hit))
    else $error("warning without warning count");

  timeout_c: cover property (timeout);
  good_feed_c: cover property (ENABLED && good_feed);
  warn_c: cover property (warn_hit);
  early_feed_c: cover property (ENABLED && seq_done && key_ok && !in_window);
endmodule : windowed_watchdog

/* File: verif/tb_top.sv */
// self-checking bench for the windowed watchdog, feed cases in a table then hand-written cases
// assumes wd_pkg and windowed_watchdog compiled first; source ticks driven as level pulses
`timescale 1ns/1ps
module tb_top;
  import wd_pkg::*;
  logic clk = 0, rst = 1, en_set = 0, rmode = 0, src = 0, otick = 0, itick = 0;
  logic wen = 0, fwr = 0, iclr = 0, wclr = 0, fclr = 0;
  logic enabled, chip_rst, rflag, wint, warn;
  logic [7:0] fdata = 8'h00;
  cnt_t tc = 24'h000100, win = 24'hFFFFFF, wval = 24'h000000, count;
  int fail_count = 0, samples_checked = 0, n;
  typedef struct {logic [7:0] k1; logic [7:0] k2; cnt_t w; logic ev;} row_s;
  row_s rows [5] = '{'{8'h5A, 8'hC3, 24'hFFFFFF, 1'b0}, '{8'h5A, 8'hC3, 24'h000200, 1'b0},
    '{8'h11, 8'hC3, 24'hFFFFFF, 1'b1}, '{8'h5A, 8'h11, 24'hFFFFFF, 1'b1},
    '{8'h5A, 8'hC3, 24'h000080, 1'b1}};
  always #12.5 clk = ~clk;
  windowed_watchdog i_dut (.CLK_SYS(clk), .RST(rst), .ENABLE_SET(en_set), .RESET_MODE(rmode),
    .SRC_SEL(src), .OSC_TICK(otick), .RC_TICK(itick), .TC_VAL(tc), .WINDOW_VAL(win), .WARN_EN(wen),
    .WARN_VAL(wval), .FEED_WR(fwr), .FEED_DATA(fdata), .INT_CLR(iclr), .WARN_CLR(wclr), .FLAG_CLR(fclr),
    .ENABLED(enabled), .COUNT(count), .CHIP_RESET_REQ(chip_rst), .RESET_FLAG(rflag), .WDOG_INT(wint),
    .WARN_INT(warn));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input cnt_t got, input cnt_t exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chkb
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("CHECK FAILED %0t wait ran out", $time);
      end_sim();
    end
  endtask : wait_hi
  task automatic pulse_en();
    @(posedge clk) en_set <= 1'b1;
    @(posedge clk) en_set <= 1'b0;
  endtask : pulse_en
  task automatic feed(input logic [7:0] k1, input logic [7:0] k2);
    @(posedge clk) begin
      fwr <= 1'b1;
      fdata <= k1;
    end
    @(posedge clk) fdata <= k2;
    @(posedge clk) fwr <= 1'b0;
  endtask : feed
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chkb(enabled, 1'b0, "enabled after reset");
    chk(count, 24'hFFFFFF, "count after reset");
    chkb(rflag, 1'b0, "flag after reset");
    // ticks held off so only enable and feeds move the count
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) begin
        win <= rows[i].w;
        tc <= 24'h000100;
        iclr <= 1'b1;
      end
      @(posedge clk) iclr <= 1'b0;
      pulse_en();
      @(posedge clk) tc <= 24'h000200;
      feed(rows[i].k1, rows[i].k2);
      step(3);
      chkb(wint, rows[i].ev, "feed event");
      chkb(enabled, !rows[i].ev, "enable after feed");
      if (!rows[i].ev) chk(count, 24'h000200, "reload value");
    end
    // time-out in reset mode, reload below minimum taken as minimum
    @(posedge clk) begin
      rmode <= 1'b1;
      tc <= 24'h000000;
      win <= 24'hFFFFFF;
      otick <= 1'b1;
    end
    pulse_en();
    wait_hi(chip_rst, 1100);
    chkb(n >= 1018 && n <= 1030, 1'b1, "time-out length");
    chkb(rflag, 1'b1, "watchdog reset flag");
    chkb(enabled, 1'b0, "disabled by event");
    chk(count, 24'h0000FF, "count after time-out");
    step(1);
    chkb(chip_rst, 1'b0, "reset request one cycle");
    @(posedge clk) fclr <= 1'b1;
    @(posedge clk) fclr <= 1'b0;
    step(1);
    chkb(rflag, 1'b0, "flag cleared");
    // warning in interrupt mode
    @(posedge clk) begin
      rmode <= 1'b0;
      tc <= 24'h000100;
      wen <= 1'b1;
      wval <= 24'h0000FC;
      iclr <= 1'b1;
    end
    @(posedge clk) iclr <= 1'b0;
    pulse_en();
    wait_hi(warn, 100);
    chk(count, 24'h0000FB, "warning count");
    chkb(wint, 1'b0, "no event at warning");
    feed(8'h11, 8'h11);
    step(2);
    chkb(wint, 1'b1, "bad feed interrupt");
    chkb(warn, 1'b1, "warning sticky");
    @(posedge clk) wclr <= 1'b1;
    @(posedge clk) wclr <= 1'b0;
    step(1);
    chkb(warn, 1'b0, "warning cleared");
    // rc source selected: watchdog oscillator ticks must not count
    @(posedge clk) begin
      src <= 1'b1;
      iclr <= 1'b1;
    end
    @(posedge clk) iclr <= 1'b0;
    pulse_en();
    step(20);
    chk(count, 24'h000100, "other source ignored");
    @(posedge clk) itick <= 1'b1;
    repeat (8) @(posedge clk);
    itick <= 1'b0;
    step(2);
    chk(count, 24'h0000FE, "prescale by four");
    pulse_en();
    step(2);
    chk(count, 24'h0000FE, "enable while enabled");
    // hardware reset while running must disable
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    step(1);
    chkb(enabled, 1'b0, "disabled by hardware reset");
    chk(count, 24'hFFFFFF, "count after hardware reset");
    end_sim();
  end
endmodule : tb_top
